// ==== pkg/ssn_pkg.sv ====
// shared constants and carrier types for the sync negotiation message block
// Operation
// - release ends recovery condition, then bus free; the code raises bus free only for a release seen in S_IDLE
// - release without condition: accept, go bus free; the code goes bus free only from S_IDLE
// - sync request is five bytes, fixed header
// - negotiate whenever agreement may be invalid
// - sync-capable device never rejects sync request
// - req spacing is four times period factor
// - offset zero async, ffh unlimited, data only
// - responder echoes or raises period, lowers offset
// - never transmit faster or deeper than allowed
// - nonzero offset sync; zero or reject async
// - initiator request answered by target reply
// - reject or parity after reply goes async
// - parity retries exhausted: abort to async
// - initiator answers target request or rejects
// - agreement valid once target leaves message out
// - no reply after retries: bus free, async
// - target rejects initiator reply: async
// - async default after power, resets
package ssn_pkg;

  localparam logic [7:0] SSN_EXT_MSG     = 8'h01;
  localparam logic [7:0] SSN_SDTR_LEN    = 8'h03;
  localparam logic [7:0] SSN_SDTR_CODE   = 8'h01;
  localparam logic [7:0] SSN_MSG_REJECT  = 8'h07;
  localparam logic [7:0] SSN_MSG_PARITY  = 8'h09;
  localparam logic [7:0] SSN_MSG_RELEASE = 8'h10;
  localparam logic [7:0] SSN_OFS_ASYNC   = 8'h00;
  localparam logic [7:0] SSN_OFS_UNLIM   = 8'hff;
  localparam logic [7:0] SSN_PER_RESET   = 8'h00;
  localparam logic [2:0] SSN_POS_LEN     = 3'h1;
  localparam logic [2:0] SSN_POS_CODE    = 3'h2;
  localparam logic [2:0] SSN_POS_PER     = 3'h3;
  localparam logic [2:0] SSN_POS_OFS     = 3'h4;
  localparam logic [2:0] SSN_SDTR_BYTES  = 3'h5;
  localparam int         SSN_PERIOD_MULT = 4;
  localparam int         SSN_CLK_NS      = 20;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ssn_rx_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } ssn_tx_t;

  typedef struct packed {
    logic       sdtr;
    logic       reject;
    logic       parity;
    logic       release_rec;
    logic       other;
    logic [7:0] period;
    logic [7:0] offset;
  } ssn_evt_t;

  typedef struct packed {
    logic [7:0] period;
    logic [7:0] offset;
  } ssn_agr_t;

endpackage

// ==== logic/ssn_msg_parser.sv ====
// message-out byte stream decoder producing one-cycle message events
`timescale 1ns/1ns
`default_nettype none
module ssn_msg_parser
  import ssn_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     reset_n,
  input  wire ssn_rx_t  rx,
  output ssn_evt_t      evt
);

  logic       ext_reg;
  logic [7:0] cnt_reg;
  logic [7:0] len_reg;
  logic [7:0] code_reg;
  logic [7:0] per_reg;
  ssn_evt_t   evt_reg;

  assign evt = evt_reg;

  // byte position inside an extended message
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_reg  <= 1'b0;
      cnt_reg  <= 8'h00;
      len_reg  <= 8'h00;
      code_reg <= 8'h00;
      per_reg  <= 8'h00;
    end
    else if (rx.valid)
    begin
      if (!ext_reg)
      begin
        ext_reg <= (rx.data == SSN_EXT_MSG);
        cnt_reg <= 8'h01;
      end
      else
      begin
        cnt_reg <= cnt_reg + 8'h01;
        if (cnt_reg == 8'(SSN_POS_LEN))
          len_reg <= rx.data;
        if (cnt_reg == 8'(SSN_POS_CODE))
          code_reg <= rx.data;
        if (cnt_reg == 8'(SSN_POS_PER))
          per_reg <= rx.data;
        // zero length is not decoded further; it closes the message and raises an other event
        if ((cnt_reg == 8'(SSN_POS_LEN) && rx.data == 8'h00) ||
            (cnt_reg > 8'(SSN_POS_LEN) && cnt_reg == len_reg + 8'h01))
          ext_reg <= 1'b0;
      end
    end
  end

  // identify bytes (bit 7) raise no event
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      evt_reg <= '0;
    else
    begin
      evt_reg <= '0;
      if (rx.valid && !ext_reg && rx.data != SSN_EXT_MSG && !rx.data[7])
      begin
        evt_reg.reject      <= (rx.data == SSN_MSG_REJECT);
        evt_reg.parity      <= (rx.data == SSN_MSG_PARITY);
        evt_reg.release_rec <= (rx.data == SSN_MSG_RELEASE);
        evt_reg.other       <= !(rx.data inside {SSN_MSG_REJECT, SSN_MSG_PARITY,
                                                 SSN_MSG_RELEASE});
      end
      else if (rx.valid && ext_reg)
      begin
        if (cnt_reg == 8'(SSN_POS_LEN) && rx.data == 8'h00)
          evt_reg.other <= 1'b1;
        else if (cnt_reg > 8'(SSN_POS_LEN) && cnt_reg == len_reg + 8'h01)
        begin
          if (len_reg == SSN_SDTR_LEN && code_reg == SSN_SDTR_CODE)
          begin
            evt_reg.sdtr   <= 1'b1;
            evt_reg.period <= per_reg;
            evt_reg.offset <= rx.data;
          end
          else
            evt_reg.other <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/ssn_agree_table.sv ====
// per-peer store of negotiated period factor and offset
`timescale 1ns/1ns
`default_nettype none
module ssn_agree_table
  import ssn_pkg::*;
#(
  parameter int N_PEER = 8,
  parameter int ID_W   = 3
)
(
  input  wire logic            mclk,
  input  wire logic            reset_n,
  input  wire logic            clr_en,
  input  wire logic [ID_W-1:0] clr_id,
  input  wire logic            wr_en,
  input  wire logic [ID_W-1:0] wr_id,
  input  wire ssn_agr_t        wr_val,
  input  wire logic [ID_W-1:0] rd_id,
  output ssn_agr_t             rd_val,
  output logic                 rd_need
);

  ssn_agr_t agr_reg  [N_PEER];
  logic     need_reg [N_PEER];

  assign rd_val  = agr_reg[rd_id];
  assign rd_need = need_reg[rd_id];

  for (genvar g = 0; g < N_PEER; g++)
  begin : g_peer
    always_ff @(posedge mclk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        agr_reg[g]  <= '{period: SSN_PER_RESET, offset: SSN_OFS_ASYNC};
        need_reg[g] <= 1'b1;
      end
      else if (clr_en && clr_id == ID_W'(g))
      begin
        agr_reg[g]  <= '{period: SSN_PER_RESET, offset: SSN_OFS_ASYNC};
        need_reg[g] <= 1'b1;
      end
      else if (wr_en && wr_id == ID_W'(g))
      begin
        agr_reg[g]  <= wr_val;
        need_reg[g] <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/ssn_negotiator.sv ====
// target-side synchronous negotiation and release recovery message control
`timescale 1ns/1ns
`default_nettype none
module ssn_negotiator
  import ssn_pkg::*;
#(
  parameter int         N_PEER     = 8,
  parameter int         ID_W       = 3,
  parameter logic [7:0] MIN_PERIOD = 8'h19,
  parameter logic [7:0] MAX_OFFSET = 8'h08,
  parameter logic [3:0] RETRY_MAX  = 4'h3
)
(
  input  wire logic            mclk,
  input  wire logic            reset_n,
  input  wire logic            bdr_evt,
  input  wire logic            connected,
  input  wire logic            atn,
  input  wire logic [ID_W-1:0] peer_id,
  input  wire ssn_rx_t         rx,
  input  wire logic            start_neg,
  input  wire logic            eca_set,
  input  wire logic            tx_ready,
  output ssn_tx_t              tx,
  output logic                 bus_free,
  output logic                 leave_msg_out,
  output logic                 eca_active,
  output ssn_agr_t             agr,
  output logic                 sync_mode,
  output logic                 unlimited_ofs,
  output logic [7:0]           req_spacing_cyc,
  output logic                 busy
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_TX_REPLY,
    S_CHECK,
    S_TX_REQ,
    S_WAIT_RESP,
    S_TX_REJECT
  } ssn_state_t;

  ssn_state_t state_reg;
  ssn_state_t state_next;
  ssn_evt_t   ev;
  logic       need;
  logic [3:0] retry_reg;
  logic [3:0] retry_next;
  logic [7:0] tx_buf_reg [5];
  logic [2:0] tx_len_reg;
  logic [2:0] tx_idx_reg;
  logic       tx_done;
  logic       ld_sdtr;
  logic       ld_reject;
  ssn_agr_t   ld_val;
  ssn_agr_t   reply_reg;
  logic       tw_en;
  ssn_agr_t   tw_val;
  logic       bus_free_reg;
  logic       leave_reg;
  logic       eca_reg;
  logic       resp_ok;
  logic [7:0] spacing_reg;
  logic [15:0] spacing_ns;

  localparam ssn_agr_t ASYNC_AGR = '{period: SSN_PER_RESET, offset: SSN_OFS_ASYNC};

  ssn_msg_parser u_parser (
    .mclk    (mclk),
    .reset_n (reset_n),
    .rx      (rx),
    .evt     (ev)
  );

  ssn_agree_table #(
    .N_PEER (N_PEER),
    .ID_W   (ID_W)
  ) u_table (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clr_en  (bdr_evt),
    .clr_id  (peer_id),
    .wr_en   (tw_en),
    .wr_id   (peer_id),
    .wr_val  (tw_val),
    .rd_id   (peer_id),
    .rd_val  (agr),
    .rd_need (need)
  );

  // one driver for the whole carrier; field-wise drivers of a variable are refused
  assign tx = '{valid: (state_reg inside {S_TX_REPLY, S_TX_REQ, S_TX_REJECT}),
                data:  tx_buf_reg[tx_idx_reg],
                last:  (tx_idx_reg == tx_len_reg - 3'h1)};
  assign tx_done  = tx.valid && tx_ready && tx.last;
  assign busy     = (state_reg != S_IDLE);

  // the initiator's reply may be slower or shallower than ours, never beyond
  assign resp_ok = (ev.period >= MIN_PERIOD) && (ev.offset <= MAX_OFFSET);

  // the offset alone decides the mode; period is ignored in async
  assign sync_mode     = (agr.offset != SSN_OFS_ASYNC);
  assign unlimited_ofs = (agr.offset == SSN_OFS_UNLIM);

  always_comb
  begin
    state_next = state_reg;
    retry_next = retry_reg;
    ld_sdtr    = 1'b0;
    ld_reject  = 1'b0;
    ld_val     = ASYNC_AGR;
    tw_en      = 1'b0;
    tw_val     = ASYNC_AGR;
    if (bdr_evt)
      state_next = S_IDLE;
    else
    begin
      unique case (state_reg)
        S_IDLE:
        begin
          if (ev.sdtr)
          begin
            // echo, raising period and lowering offset only where needed
            ld_sdtr       = 1'b1;
            ld_val.period = (ev.period < MIN_PERIOD) ? MIN_PERIOD : ev.period;
            ld_val.offset = (ev.offset > MAX_OFFSET) ? MAX_OFFSET : ev.offset;
            retry_next    = 4'h0;
            state_next    = S_TX_REPLY;
          end
          else if (!ev.release_rec && (start_neg || (connected && need)))
          begin
            ld_sdtr       = 1'b1;
            ld_val.period = MIN_PERIOD;
            ld_val.offset = MAX_OFFSET;
            retry_next    = 4'h0;
            state_next    = S_TX_REQ;
          end
        end
        S_TX_REPLY:
        begin
          if (tx_done)
          begin
            tw_en      = 1'b1;
            tw_val     = reply_reg;
            state_next = atn ? S_CHECK : S_IDLE;
          end
        end
        S_CHECK:
        begin
          if (ev.reject)
          begin
            tw_en      = 1'b1;
            state_next = S_IDLE;
          end
          else if (ev.parity)
          begin
            tw_en = 1'b1;
            if (retry_reg == RETRY_MAX)
              state_next = S_IDLE;
            else
            begin
              // resend restores the agreement when it completes
              retry_next = retry_reg + 4'h1;
              state_next = S_TX_REPLY;
            end
          end
          else if (ev.sdtr || ev.other || ev.release_rec || !atn)
            state_next = S_IDLE;
        end
        S_TX_REQ:
        begin
          if (tx_done)
          begin
            if (atn)
              state_next = S_WAIT_RESP;
            else
            begin
              tw_en      = 1'b1;
              state_next = S_IDLE;
            end
          end
        end
        S_WAIT_RESP:
        begin
          if (ev.sdtr && resp_ok)
          begin
            tw_en      = 1'b1;
            tw_val     = '{period: ev.period, offset: ev.offset};
            state_next = S_IDLE;
          end
          else if (ev.sdtr)
          begin
            tw_en      = 1'b1;
            ld_reject  = 1'b1;
            state_next = S_TX_REJECT;
          end
          else if (ev.reject)
          begin
            tw_en      = 1'b1;
            state_next = S_IDLE;
          end
          else if (ev.parity || ev.other)
          begin
            if (retry_reg == RETRY_MAX)
            begin
              tw_en      = 1'b1;
              state_next = S_IDLE;
            end
            else
            begin
              retry_next = retry_reg + 4'h1;
              ld_sdtr    = 1'b1;
              ld_val     = '{period: MIN_PERIOD, offset: MAX_OFFSET};
              state_next = S_TX_REQ;
            end
          end
        end
        S_TX_REJECT:
        begin
          if (tx_done)
            state_next = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= S_IDLE;
      retry_reg <= 4'h0;
    end
    else
    begin
      state_reg <= state_next;
      retry_reg <= retry_next;
    end
  end

  // outgoing message buffer
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 5; i++)
        tx_buf_reg[i] <= 8'h00;
      tx_len_reg <= 3'h0;
      tx_idx_reg <= 3'h0;
      reply_reg  <= ASYNC_AGR;
    end
    else if (ld_sdtr)
    begin
      tx_buf_reg[0]           <= SSN_EXT_MSG;
      tx_buf_reg[SSN_POS_LEN] <= SSN_SDTR_LEN;
      tx_buf_reg[SSN_POS_CODE] <= SSN_SDTR_CODE;
      tx_buf_reg[SSN_POS_PER] <= ld_val.period;
      tx_buf_reg[SSN_POS_OFS] <= ld_val.offset;
      tx_len_reg              <= SSN_SDTR_BYTES;
      tx_idx_reg              <= 3'h0;
      reply_reg               <= ld_val;
    end
    else if (ld_reject)
    begin
      tx_buf_reg[0] <= SSN_MSG_REJECT;
      tx_len_reg    <= 3'h1;
      tx_idx_reg    <= 3'h0;
    end
    else if (state_reg == S_CHECK && state_next == S_TX_REPLY)
      tx_idx_reg <= 3'h0;
    else if (tx.valid && tx_ready && !tx.last)
      tx_idx_reg <= tx_idx_reg + 3'h1;
  end

  // bus free and message-out exit pulses
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_free_reg <= 1'b0;
      leave_reg    <= 1'b0;
    end
    else
    begin
      bus_free_reg <= !bdr_evt &&
                      ((state_reg == S_IDLE && ev.release_rec) ||
                       (state_reg == S_CHECK && ev.parity && retry_reg == RETRY_MAX) ||
                       (state_reg == S_WAIT_RESP && (ev.parity || ev.other) &&
                        retry_reg == RETRY_MAX));
      leave_reg    <= !bdr_evt && state_reg == S_WAIT_RESP && ev.sdtr && resp_ok;
    end
  end

  assign bus_free      = bus_free_reg;
  assign leave_msg_out = leave_reg;
  assign eca_active    = eca_reg;

  // a new condition raised in the same cycle outlives the release
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      eca_reg <= 1'b0;
    else if (eca_set)
      eca_reg <= 1'b1;
    else if (ev.release_rec)
      eca_reg <= 1'b0;
  end

  // rounded up so the peer's minimum spacing is never undercut
  assign spacing_ns = 16'(agr.period) * 16'(SSN_PERIOD_MULT);
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      spacing_reg <= 8'h01;
    else if (spacing_ns == 16'h0000)
      spacing_reg <= 8'h01;
    else
      spacing_reg <= 8'((spacing_ns + 16'(SSN_CLK_NS - 1)) / 16'(SSN_CLK_NS));
  end
  assign req_spacing_cyc = spacing_reg;

  property p_release_bus_free;
    @(posedge mclk) disable iff (!reset_n)
    state_reg == S_IDLE && ev.release_rec && !bdr_evt |=> bus_free ##1 !bus_free;
  endproperty
  a_release_bus_free: assert property (p_release_bus_free) else $error("no bus free after release");

  property p_release_ends_eca;
    @(posedge mclk) disable iff (!reset_n)
    ev.release_rec && !eca_set |=> !eca_active;
  endproperty
  a_release_ends_eca: assert property (p_release_ends_eca) else $error("recovery not ended");

  property p_never_reject;
    @(posedge mclk) disable iff (!reset_n)
    state_reg == S_IDLE && ev.sdtr && !bdr_evt |=> state_reg == S_TX_REPLY && tx.data == SSN_EXT_MSG;
  endproperty
  a_never_reject: assert property (p_never_reject) else $error("sync request not answered");

  property p_reply_limits;
    @(posedge mclk) disable iff (!reset_n)
    state_reg == S_TX_REPLY && tx_idx_reg == SSN_POS_PER |->
      tx.data >= MIN_PERIOD ##0 (tx_buf_reg[SSN_POS_OFS] <= MAX_OFFSET);
  endproperty
  a_reply_limits: assert property (p_reply_limits) else $error("reply exceeds own limits");

  property p_bdr_async;
    @(posedge mclk) disable iff (!reset_n)
    bdr_evt ##1 $stable(peer_id) |-> !sync_mode && state_reg == S_IDLE;
  endproperty
  a_bdr_async: assert property (p_bdr_async) else $error("agreement kept after device reset");

  property p_spacing;
    @(posedge mclk) disable iff (!reset_n)
    $stable(agr.period) |->
      int'(req_spacing_cyc) * SSN_CLK_NS >= int'(agr.period) * SSN_PERIOD_MULT;
  endproperty
  a_spacing: assert property (p_spacing) else $error("req spacing too short");

  property p_unlimited;
    @(posedge mclk) disable iff (!reset_n)
    agr.offset == SSN_OFS_UNLIM |-> unlimited_ofs && sync_mode;
  endproperty
  a_unlimited: assert property (p_unlimited) else $error("unlimited offset not flagged");

  property p_reject_async;
    @(posedge mclk) disable iff (!reset_n)
    state_reg == S_CHECK && (ev.reject || ev.parity) && !bdr_evt ##1 $stable(peer_id) |->
      !sync_mode;
  endproperty
  a_reject_async: assert property (p_reject_async) else $error("agreement kept after reject");

  property p_retry_abort;
    @(posedge mclk) disable iff (!reset_n)
    state_reg == S_WAIT_RESP && (ev.parity || ev.other) && retry_reg == RETRY_MAX &&
      !bdr_evt |=> bus_free && state_reg == S_IDLE;
  endproperty
  a_retry_abort: assert property (p_retry_abort) else $error("retries not ended by bus free");

  property p_accept_leave;
    @(posedge mclk) disable iff (!reset_n)
    state_reg == S_WAIT_RESP && ev.sdtr && resp_ok && !bdr_evt |=>
      leave_msg_out && agr.offset == $past(ev.offset);
  endproperty
  a_accept_leave: assert property (p_accept_leave) else $error("accepted reply not applied");

  c_reply: cover property (@(posedge mclk) disable iff (!reset_n)
    state_reg == S_TX_REPLY && tx_done);
  c_accept: cover property (@(posedge mclk) disable iff (!reset_n) leave_msg_out);
  c_release: cover property (@(posedge mclk) disable iff (!reset_n) bus_free && eca_active == 1'b0);

endmodule
`default_nettype wire

// ==== verification/ssn_init_model.sv ====
// initiator-side partner: feeds message-out bytes and stalls message-in acceptance
`timescale 1ns/1ns
`default_nettype none
module ssn_init_model
  import ssn_pkg::*;
(
  input  wire logic    mclk,
  input  wire ssn_tx_t tx,
  output ssn_rx_t      rx,
  output logic         tx_ready
);
  integer seed = 67556;
  // zero marks the start of each area
  logic [15:0] cur_dp = 16'h0000;
  logic [15:0] sav_dp = 16'h0000;
  logic [15:0] cur_cp = 16'h0000;
  logic [15:0] cur_sp = 16'h0000;

  task automatic save_ptr;
    sav_dp = cur_dp;
  endtask

  // no save yet leaves the saved pointer at the area start
  task automatic restore_ptr;
    cur_dp = sav_dp;
    cur_cp = 16'h0000;
    cur_sp = 16'h0000;
  endtask

  initial
  begin
    rx = '0;
  end

  // random stalls so every reply byte must hold until taken
  always @(negedge mclk)
    tx_ready <= |($random(seed) & 3);

  task automatic send(input logic [7:0] b);
    @(negedge mclk);
    rx = '{valid: 1'b1, data: b};
    @(negedge mclk);
    // a released line must not look like the last byte
    rx = '{valid: 1'b0, data: ~b};
  endtask
endmodule
`default_nettype wire

// ==== verification/ssn_negotiator_tb.sv ====
// self-checking bench for the target-side sync negotiation block
`timescale 1ns/1ns
`default_nettype none
module ssn_negotiator_tb;
  import ssn_pkg::*;
  localparam logic [7:0] MINP = 8'h19;
  localparam logic [7:0] MAXO = 8'h10;
  logic       mclk, reset_n, bdr_evt, connected, atn, start_neg, eca_set, tx_ready;
  logic       bus_free, leave_msg_out, eca_active, sync_mode, unlimited_ofs, busy;
  logic [2:0] peer_id;
  logic [7:0] req_spacing_cyc, p, o;
  ssn_rx_t    rx;
  ssn_tx_t    tx;
  ssn_agr_t   agr;
  logic [7:0] exp_q[$];
  int         miscompares = 0;
  int         comparisons = 0;

  ssn_negotiator #(.MIN_PERIOD(MINP), .MAX_OFFSET(MAXO)) dut (
    .mclk(mclk), .reset_n(reset_n), .bdr_evt(bdr_evt), .connected(connected), .atn(atn),
    .peer_id(peer_id), .rx(rx), .start_neg(start_neg), .eca_set(eca_set),
    .tx_ready(tx_ready), .tx(tx), .bus_free(bus_free), .leave_msg_out(leave_msg_out),
    .eca_active(eca_active), .agr(agr), .sync_mode(sync_mode),
    .unlimited_ofs(unlimited_ofs), .req_spacing_cyc(req_spacing_cyc), .busy(busy));
  ssn_init_model m (.mclk(mclk), .tx(tx), .rx(rx), .tx_ready(tx_ready));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // every accepted message-in byte against the oldest note
  always @(posedge mclk)
    if (tx.valid === 1'b1 && tx_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("tx unexpected", 16'h0100, {8'h00, tx.data});
      else
        check("tx byte", {8'h00, exp_q.pop_front()}, {8'h00, tx.data});
    end

  task automatic exp_sdtr(input logic [7:0] per, input logic [7:0] ofs);
    exp_q.push_back(SSN_EXT_MSG);
    exp_q.push_back(SSN_SDTR_LEN);
    exp_q.push_back(SSN_SDTR_CODE);
    exp_q.push_back(per);
    exp_q.push_back(ofs);
  endtask

  task automatic send_sdtr(input logic [7:0] per, input logic [7:0] ofs);
    m.send(SSN_EXT_MSG);
    m.send(SSN_SDTR_LEN);
    m.send(SSN_SDTR_CODE);
    m.send(per);
    m.send(ofs);
  endtask

  task automatic drain;
    int n;
    n = 0;
    while ((exp_q.size() != 0 || tx.valid !== 1'b0) && n < 300)
    begin
      @(negedge mclk);
      n++;
    end
    check("drain bound", 16'h0001, {15'h0, n < 300});
    if (n == 300)
      complete_run;
    repeat (3) @(negedge mclk);
  endtask

  task automatic wait_pulse(input string what, input bit lv);
    int n;
    n = 0;
    while ((lv ? leave_msg_out : bus_free) !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    check(what, 16'h0001, {15'h0, n < 20});
    if (n == 20)
      complete_run;
    @(negedge mclk);
  endtask

  task automatic chk_agr(input logic [7:0] per, input logic [7:0] ofs);
    int sp;
    // spacing trails the agreement by one cycle
    repeat (2) @(negedge mclk);
    sp = (int'(per) * SSN_PERIOD_MULT + SSN_CLK_NS - 1) / SSN_CLK_NS;
    if (sp < 1)
      sp = 1;
    check("agreement", {per, ofs}, agr);
    check("sync_mode", {15'h0, ofs != 8'h00}, {15'h0, sync_mode});
    check("unlimited_ofs", {15'h0, ofs == 8'hff}, {15'h0, unlimited_ofs});
    check("req_spacing", sp[15:0], {8'h00, req_spacing_cyc});
  endtask

  // every resend after the original, then one more failure ends in bus free
  task automatic retry_out(input logic [7:0] msg);
    for (int i = 0; i < 3; i++)
    begin
      exp_sdtr(MINP, MAXO);
      m.send(msg);
      drain;
    end
    m.send(msg);
    wait_pulse("retry bus_free", 1'b0);
    chk_agr(8'h00, 8'h00);
  endtask

  initial
  begin
    reset_n = 1'b0;
    bdr_evt = 1'b0;
    connected = 1'b0;
    atn = 1'b0;
    peer_id = 3'h2;
    start_neg = 1'b0;
    eca_set = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    chk_agr(8'h00, 8'h00);
    check("busy", 16'h0, {15'h0, busy});
    $display("test reset_defaults done");
    exp_sdtr(MINP, MAXO);
    atn = 1'b1;
    connected = 1'b1;
    drain;
    connected = 1'b0;
    send_sdtr(8'h20, 8'h08);
    wait_pulse("leave", 1'b1);
    chk_agr(8'h20, 8'h08);
    $display("test target_start done");
    for (int i = 0; i < 8; i++)
    begin
      p = (i == 0) ? MINP : (i == 1) ? 8'h0c : 8'($random(m.seed));
      o = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(m.seed));
      atn = 1'b1;
      exp_sdtr((p < MINP) ? MINP : p, (o > MAXO) ? MAXO : o);
      send_sdtr(p, o);
      atn = 1'b0;
      drain;
      chk_agr((p < MINP) ? MINP : p, (o > MAXO) ? MAXO : o);
    end
    $display("test initiator_start done");
    atn = 1'b1;
    exp_sdtr(8'h20, 8'h08);
    send_sdtr(8'h20, 8'h08);
    drain;
    m.send(SSN_MSG_REJECT);
    chk_agr(8'h00, 8'h00);
    exp_sdtr(MINP, MAXO);
    send_sdtr(8'h10, 8'h20);
    drain;
    retry_out(SSN_MSG_PARITY);
    exp_sdtr(8'h20, 8'h08);
    send_sdtr(8'h20, 8'h08);
    drain;
    exp_sdtr(8'h20, 8'h08);
    m.send(SSN_MSG_PARITY);
    drain;
    m.send(8'h08);
    chk_agr(8'h20, 8'h08);
    $display("test reply_failures done");
    atn = 1'b0;
    @(negedge mclk);
    eca_set = 1'b1;
    @(negedge mclk);
    eca_set = 1'b0;
    check("eca set", 16'h0001, {15'h0, eca_active});
    m.send(8'h80);
    m.send(SSN_MSG_RELEASE);
    wait_pulse("release bus_free", 1'b0);
    check("eca cleared", 16'h0, {15'h0, eca_active});
    m.send(SSN_MSG_RELEASE);
    wait_pulse("release idle bus_free", 1'b0);
    $display("test release done");
    atn = 1'b1;
    connected = 1'b1;
    exp_sdtr(MINP, MAXO);
    bdr_evt = 1'b1;
    @(negedge mclk);
    bdr_evt = 1'b0;
    chk_agr(8'h00, 8'h00);
    drain;
    connected = 1'b0;
    m.send(SSN_MSG_REJECT);
    chk_agr(8'h00, 8'h00);
    $display("test device_reset done");
    start_neg = 1'b1;
    exp_sdtr(MINP, MAXO);
    @(negedge mclk);
    start_neg = 1'b0;
    drain;
    exp_q.push_back(SSN_MSG_REJECT);
    send_sdtr(8'h10, 8'h08);
    drain;
    chk_agr(8'h00, 8'h00);
    start_neg = 1'b1;
    exp_sdtr(MINP, MAXO);
    @(negedge mclk);
    start_neg = 1'b0;
    drain;
    retry_out(8'h08);
    $display("test target_failures done");
    m.cur_dp = 16'h0040;
    m.cur_cp = 16'h0003;
    m.restore_ptr;
    check("data ptr unsaved", 16'h0000, m.cur_dp);
    check("cmd ptr", 16'h0000, m.cur_cp);
    m.cur_dp = 16'h0040;
    m.save_ptr;
    m.cur_dp = 16'h0080;
    m.restore_ptr;
    check("data ptr saved", 16'h0040, m.cur_dp);
    $display("test pointers done");
    check("queue left", 16'h0000, 16'(exp_q.size()));
    complete_run;
  end
endmodule
`default_nettype wire
